// ---- diag_regs.svh ----
// Constants of the diagnostic port.
// Functional notes
// [R1] Address 0x30 to 0x33, low bits from select pin at enable.
// [R2] General call address is never acknowledged.
// [R3] Clock line never held low.
// [R4] Data held low through the ninth clock.
// [R5] Eight bits, then one acknowledge clock.
// [R6] Data falling with clock high is START, rising is STOP.
// [R7] STOP aborts a transfer, unless in the START's high pulse.
// [R8] Master drives the clock, at most 400 kHz.
// [R9] Sender holds data stable while clock is high.
// [R10] Write: START, address+0, register, data, STOP.
// [R11] Read: START, address+0, register, START, address+1, byte, STOP.
// [R12] First byte: seven address bits, then direction, 1 reads.
// [R13] Interrupt only while an enabled flag is set.
// [R14] Masks gate only the interrupt, not the fault pin.
// [R15] Request bit starts a measurement; done clears it, flags.
// [R16] Samples hold until the next request; the code holds them until the next done.
// [R17] 8-bit codes; voltage code 255 is 19.8 V.
// [R18] Current code spans 0 to 128.5 mV sense voltage.
// [R19] Temperature is 3.5 degrees times code minus 270.
// [R20] Flags clear on read, set again while the fault persists.
// [R21] No acknowledge for a foreign address.
// [R22] Interrupt open drain, active low, released when idle.
`ifndef DIAG_REGS_SVH
`define DIAG_REGS_SVH

`define ADDR_UPPER      5'h0c
`define GEN_CALL_ADDR   7'h00
`define ACK_SLOT        4'h8
`define FIRST_BIT_CNT   4'h1

`define REG_CONV_REQ    8'h05
`define REG_MASK0       8'h07
`define REG_MASK1       8'h08
`define REG_MASK2       8'h09
`define REG_FLAG0       8'h0a
`define REG_FLAG1       8'h0b
`define REG_FLAG2       8'h0c
`define REG_SAMPLE_I    8'h10
`define REG_SAMPLE_V    8'h11
`define REG_SAMPLE_T    8'h12

`define CONV_REQ_BIT    0
`define MASK_RESET      8'h00
`define FLAG_RESET      8'h00
`define SAMPLE_RESET    8'h00
`define FLAG0_EXT_BITS  8'h7e
`define FLAG1_BITS      8'h7f
`define FLAG2_BITS      8'h3f
`define FAULT1_BITS     8'h7f
`define FAULT2_BITS     8'h07
`define NO_DATA         8'hff

`define CODE_FULL       32'd255
`define VBUS_FULL_MV    32'd19800
`define SENSE_FULL_UV   32'd128500
`define TEMP_STEP_DC    16'd35
`define TEMP_OFFSET_DC  16'd2700

`endif

// ---- diag_pkg.sv ----
// Types of the diagnostic port.
package diag_pkg;

    typedef enum logic [2:0] {
        LS_IDLE   = 3'b000,
        LS_ADDR   = 3'b001,
        LS_REG    = 3'b010,
        LS_WDATA  = 3'b011,
        LS_RDATA  = 3'b100,
        LS_IGNORE = 3'b101
    } link_state_t;

    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] data;
    } wr_cmd_t;

    typedef struct packed {
        logic [7:0] voltage;
        logic [7:0] current;
        logic [7:0] temp;
    } sample_set_t;

    typedef struct packed {
        logic [7:0] ev0;
        logic [7:0] ev1;
        logic [7:0] ev2;
    } event_vec_t;

endpackage

// ---- i2c_link_engine.sv ----
// Serial byte engine on the link clock.
`timescale 1ns/1ns
`default_nettype none
`include "diag_regs.svh"
module i2c_link_engine (
    // Link clock and data
    input  wire logic              i_scl,
    input  wire logic              i_sda,
    output logic                   o_sda_oe,
    // Core side
    input  wire logic              i_reset_n,
    input  wire logic [1:0]        i_addr_sel,
    input  wire logic              i_frame_req,
    output logic                   o_frame_ack,
    input  wire logic [7:0]        i_rd_data,
    input  wire logic              i_ptr_ack_tog,
    output diag_pkg::wr_cmd_t      o_cmd,
    output logic                   o_ptr_tog,
    output logic                   o_wr_tog,
    output logic                   o_rd_tog
);
    logic [1:0]              rst_q;
    logic [3:0]              sel_q;
    logic [1:0]              ack_tog_q;
    logic                    frame_q1;
    logic                    frame_q2;
    diag_pkg::link_state_t   state_q;
    logic [3:0]              cnt_q;
    logic [7:0]              shift_q;
    logic [7:0]              rd_byte_q;
    logic                    pos_sda_q;
    logic                    rs_tog_q;
    logic                    rs_seen_q;
    logic                    match;
    logic                    at_ack;

    assign at_ack = (cnt_q == `ACK_SLOT);
    assign match = (shift_q[7:1] == {`ADDR_UPPER, sel_q[3:2]})
                   && (shift_q[7:1] != `GEN_CALL_ADDR); // [R1] [R2]
    assign o_frame_ack = frame_q2;

    always_ff @(posedge i_scl) begin
        rst_q <= {rst_q[0], i_reset_n};
        sel_q <= {sel_q[1:0], i_addr_sel};
        ack_tog_q <= {ack_tog_q[0], i_ptr_ack_tog};
        frame_q2 <= frame_q1;
        pos_sda_q <= i_sda;
        rs_seen_q <= rs_tog_q;
    end

    always_ff @(negedge i_scl) begin
        frame_q1 <= i_frame_req;
    end

    // A STOP restart lands one bit late; that first bit is kept.
    always_ff @(posedge i_scl) begin
        if (!rst_q[1]) begin
            state_q <= diag_pkg::LS_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
        end else if (rs_tog_q != rs_seen_q) begin // [R6]
            state_q <= diag_pkg::LS_ADDR;
            cnt_q <= `FIRST_BIT_CNT;
            shift_q <= {7'h00, i_sda};
        end else if (frame_q2) begin // [R7]
            state_q <= diag_pkg::LS_ADDR;
            cnt_q <= `FIRST_BIT_CNT + 4'h1;
            shift_q <= {6'h00, pos_sda_q, i_sda};
        end else begin
            unique case (state_q)
                diag_pkg::LS_ADDR, diag_pkg::LS_REG, diag_pkg::LS_WDATA: begin
                    if (!at_ack) begin
                        shift_q <= {shift_q[6:0], i_sda}; // [R5] [R9]
                        cnt_q <= cnt_q + 4'h1;
                    end else begin
                        cnt_q <= 4'h0;
                        if (state_q == diag_pkg::LS_ADDR) begin
                            if (!match) begin
                                state_q <= diag_pkg::LS_IGNORE;
                            end else if (shift_q[0]) begin
                                state_q <= diag_pkg::LS_RDATA; // [R12]
                            end else begin
                                state_q <= diag_pkg::LS_REG;
                            end
                        end else if (state_q == diag_pkg::LS_REG) begin
                            state_q <= diag_pkg::LS_WDATA; // [R10]
                        end else begin
                            state_q <= diag_pkg::LS_IGNORE;
                        end
                    end
                end
                diag_pkg::LS_RDATA: begin
                    if (!at_ack) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else begin
                        cnt_q <= 4'h0;
                        state_q <= diag_pkg::LS_IGNORE; // [R11]
                    end
                end
                diag_pkg::LS_IDLE, diag_pkg::LS_IGNORE: begin
                    cnt_q <= cnt_q;
                end
                default: begin
                    state_q <= diag_pkg::LS_IDLE;
                end
            endcase
        end
    end

    // Commands to the core by toggles.
    always_ff @(posedge i_scl) begin
        if (!rst_q[1]) begin
            o_cmd <= '0;
            o_ptr_tog <= 1'b0;
            o_wr_tog <= 1'b0;
            o_rd_tog <= 1'b0;
            rd_byte_q <= `NO_DATA;
        end else if (at_ack && !frame_q2 && (rs_tog_q == rs_seen_q)) begin
            if (state_q == diag_pkg::LS_REG) begin
                o_cmd.ptr <= shift_q;
                o_ptr_tog <= ~o_ptr_tog;
            end
            if (state_q == diag_pkg::LS_WDATA) begin
                o_cmd.data <= shift_q;
                o_wr_tog <= ~o_wr_tog;
            end
            if (state_q == diag_pkg::LS_ADDR) begin
                rd_byte_q <= (ack_tog_q[1] == o_ptr_tog) ? i_rd_data : `NO_DATA;
            end
            if (state_q == diag_pkg::LS_RDATA) begin
                o_rd_tog <= ~o_rd_tog;
            end
        end
    end

    // Data pin changes on falling clock edges only.
    always_ff @(negedge i_scl) begin
        if (!rst_q[1]) begin
            o_sda_oe <= 1'b0;
            rs_tog_q <= 1'b0;
        end else begin
            if (!i_sda && pos_sda_q) begin
                rs_tog_q <= ~rs_tog_q; // [R6]
            end
            if (state_q == diag_pkg::LS_RDATA) begin
                o_sda_oe <= !at_ack && !rd_byte_q[3'(4'h7 - cnt_q)];
            end else if (at_ack) begin
                o_sda_oe <= (state_q == diag_pkg::LS_REG)
                            || (state_q == diag_pkg::LS_WDATA)
                            || ((state_q == diag_pkg::LS_ADDR) && match); // [R4] [R21]
            end else begin
                o_sda_oe <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ---- i2c_diag_host_port.sv ----
// Serial diagnostic slave port.
`timescale 1ns/1ns
`default_nettype none
`include "diag_regs.svh"
module i2c_diag_host_port (
    // Clock and reset
    input  wire logic                   i_core_clk,
    input  wire logic                   i_reset_n,
    // Serial clock pin, input only
    input  wire logic                   i_scl,
    output logic                        o_scl_o,
    output logic                        o_scl_oe,
    // Serial data pin, open drain
    input  wire logic                   i_sda,
    output logic                        o_sda_o,
    output logic                        o_sda_oe,
    // Interrupt pin, open drain, active low
    output logic                        o_int_n_o,
    output logic                        o_int_n_oe,
    // Fault pin, open drain, active low
    output logic                        o_fault_n_o,
    output logic                        o_fault_n_oe,
    // Configuration
    input  wire logic                   i_enable,
    input  wire logic [1:0]             i_address_select_pin,
    output logic [6:0]                  o_own_addr,
    // Event and fault sources
    input  wire diag_pkg::event_vec_t   i_events,
    // Converter handshake
    output logic                        o_conv_start,
    output logic                        o_conv_busy,
    input  wire logic                   i_conv_done,
    input  wire diag_pkg::sample_set_t  i_samples,
    // Measurement results
    output var diag_pkg::sample_set_t   o_samples,
    output logic [15:0]                 o_bus_voltage_mv,
    output logic [16:0]                 o_load_sense_uv,
    output logic signed [15:0]          o_die_temp_dc
);

    // Pin and crossing synchronisers.
    logic [2:0]              scl_q;
    logic [2:0]              sda_q;
    logic [2:0]              en_q;
    logic [1:0]              sel_meta_q;
    logic [1:0]              sel_sync_q;
    logic [3:0]              tog_meta_q;
    logic [3:0]              tog_sync_q;
    logic [2:0]              tog_last_q;

    // Bus condition tracking.
    logic                    start_seen;
    logic                    stop_seen;
    logic                    start_in_pulse_q;
    logic                    frame_req_q;

    // Link engine wiring.
    diag_pkg::wr_cmd_t       cmd;
    logic                    ptr_tog;
    logic                    wr_tog;
    logic                    rd_tog;
    logic                    frame_ack;
    logic                    ptr_evt;
    logic                    wr_evt;
    logic                    rd_evt;

    // Register state.
    logic [1:0]              own_sel_q;
    logic [7:0]              ptr_q;
    logic                    ptr_ack_tog_q;
    logic                    ptr_ack_d;
    logic [7:0]              rd_data_d;
    logic [7:0]              rd_data_q;
    logic [7:0]              mask0_q;
    logic [7:0]              mask1_q;
    logic [7:0]              mask2_q;
    logic [7:0]              flag0_q;
    logic [7:0]              flag1_q;
    logic [7:0]              flag2_q;
    logic                    conv_req_q;
    logic                    conv_done_evt;
    logic                    req_write;
    diag_pkg::sample_set_t   samples_q;
    logic                    fault_d;
    logic                    int_d;

    function automatic logic [7:0] next_flag(
        input logic [7:0] cur,
        input logic [7:0] set,
        input logic       clr
    );
        next_flag = (clr ? `FLAG_RESET : cur) | set;
    endfunction

    function automatic logic [31:0] code_scale(input logic [7:0] code, input logic [31:0] full);
        code_scale = ({24'h0, code} * full) / `CODE_FULL;
    endfunction

    function automatic logic [15:0] code_to_dc(input logic [7:0] code);
        logic [15:0] prod;
        prod = {8'h0, code} * `TEMP_STEP_DC;
        code_to_dc = prod - `TEMP_OFFSET_DC;
    endfunction

    // Clock pin never driven.
    assign o_scl_o = 1'b0;
    assign o_scl_oe = 1'b0; // [R3]
    assign o_sda_o = 1'b0;
    assign o_int_n_o = 1'b0;
    assign o_fault_n_o = 1'b0;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            scl_q <= 3'b111;
            sda_q <= 3'b111;
            en_q <= 3'b000;
            sel_meta_q <= 2'b00;
            sel_sync_q <= 2'b00;
        end else begin
            scl_q <= {scl_q[1:0], i_scl};
            sda_q <= {sda_q[1:0], i_sda};
            en_q <= {en_q[1:0], i_enable};
            sel_meta_q <= i_address_select_pin;
            sel_sync_q <= sel_meta_q;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            tog_meta_q <= 4'h0;
            tog_sync_q <= 4'h0;
            tog_last_q <= 3'h0;
        end else begin
            tog_meta_q <= {frame_ack, rd_tog, wr_tog, ptr_tog};
            tog_sync_q <= tog_meta_q;
            tog_last_q <= tog_sync_q[2:0];
        end
    end

    assign ptr_evt = tog_sync_q[0] ^ tog_last_q[0];
    assign wr_evt = tog_sync_q[1] ^ tog_last_q[1];
    assign rd_evt = tog_sync_q[2] ^ tog_last_q[2];

    // Bus conditions seen on the synchronised pins.
    assign start_seen = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1]; // [R6]
    assign stop_seen = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1]; // [R6]

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            start_in_pulse_q <= 1'b0;
        end else if (!scl_q[1]) begin
            start_in_pulse_q <= 1'b0;
        end else if (start_seen) begin
            start_in_pulse_q <= 1'b1;
        end
    end

    // A STOP restarts link framing.
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            frame_req_q <= 1'b1;
        end else if (stop_seen && !start_in_pulse_q) begin
            frame_req_q <= 1'b1; // [R7]
        end else if (tog_sync_q[3]) begin
            frame_req_q <= 1'b0;
        end
    end

    // Address low bits latched at enable.
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            own_sel_q <= 2'b00;
        end else if (en_q[1] && !en_q[2]) begin
            own_sel_q <= sel_sync_q; // [R1]
        end
    end

    assign o_own_addr = {`ADDR_UPPER, own_sel_q};

    i2c_link_engine u_link (
        .i_scl         (i_scl),
        .i_sda         (i_sda),
        .o_sda_oe      (o_sda_oe),
        .i_reset_n     (i_reset_n),
        .i_addr_sel    (own_sel_q),
        .i_frame_req   (frame_req_q),
        .o_frame_ack   (frame_ack),
        .i_rd_data     (rd_data_q),
        .i_ptr_ack_tog (ptr_ack_tog_q),
        .o_cmd         (cmd),
        .o_ptr_tog     (ptr_tog),
        .o_wr_tog      (wr_tog),
        .o_rd_tog      (rd_tog)
    );

    // Pointer from the link; ack on the same edge as read data.
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            ptr_q <= 8'h00;
            ptr_ack_d <= 1'b0;
            ptr_ack_tog_q <= 1'b0;
        end else begin
            ptr_ack_d <= ptr_evt;
            if (ptr_evt) begin
                ptr_q <= cmd.ptr;
            end
            if (ptr_ack_d) begin
                ptr_ack_tog_q <= ~ptr_ack_tog_q;
            end
        end
    end

    always_comb begin
        unique case (ptr_q)
            `REG_CONV_REQ: rd_data_d = {7'h00, conv_req_q};
            `REG_MASK0:    rd_data_d = mask0_q;
            `REG_MASK1:    rd_data_d = mask1_q;
            `REG_MASK2:    rd_data_d = mask2_q;
            `REG_FLAG0:    rd_data_d = flag0_q;
            `REG_FLAG1:    rd_data_d = flag1_q;
            `REG_FLAG2:    rd_data_d = flag2_q;
            `REG_SAMPLE_I: rd_data_d = samples_q.current;
            `REG_SAMPLE_V: rd_data_d = samples_q.voltage;
            `REG_SAMPLE_T: rd_data_d = samples_q.temp;
            default:       rd_data_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    // Event enable masks.
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            mask0_q <= `MASK_RESET;
            mask1_q <= `MASK_RESET;
            mask2_q <= `MASK_RESET;
        end else if (wr_evt) begin
            if (cmd.ptr == `REG_MASK0) begin
                mask0_q <= cmd.data;
            end
            if (cmd.ptr == `REG_MASK1) begin
                mask1_q <= cmd.data;
            end
            if (cmd.ptr == `REG_MASK2) begin
                mask2_q <= cmd.data;
            end
        end
    end

    // Measurement request bit.
    assign req_write = wr_evt && (cmd.ptr == `REG_CONV_REQ)
                       && cmd.data[`CONV_REQ_BIT];
    assign conv_done_evt = conv_req_q && i_conv_done;
    assign o_conv_busy = conv_req_q;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            conv_req_q <= 1'b0;
            o_conv_start <= 1'b0;
        end else begin
            o_conv_start <= req_write && !conv_req_q; // [R15]
            if (req_write) begin
                conv_req_q <= 1'b1; // [R15]
            end else if (conv_done_evt) begin
                conv_req_q <= 1'b0; // [R15]
            end
        end
    end

    // Samples held until done.
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            samples_q <= {`SAMPLE_RESET, `SAMPLE_RESET, `SAMPLE_RESET};
        end else if (conv_done_evt) begin
            samples_q <= i_samples; // [R16] [R17]
        end
    end

    assign o_samples = samples_q;

    // Scaled values.
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_bus_voltage_mv <= 16'h0000;
            o_load_sense_uv <= 17'h00000;
            o_die_temp_dc <= 16'h0000;
        end else begin
            o_bus_voltage_mv <= 16'(code_scale(samples_q.voltage, `VBUS_FULL_MV)); // [R17]
            o_load_sense_uv <= 17'(code_scale(samples_q.current, `SENSE_FULL_UV)); // [R18]
            o_die_temp_dc <= $signed(code_to_dc(samples_q.temp)); // [R19]
        end
    end

    // Sticky flags; set wins over read.
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            flag0_q <= `FLAG_RESET;
            flag1_q <= `FLAG_RESET;
            flag2_q <= `FLAG_RESET;
        end else begin
            flag0_q <= next_flag(flag0_q,
                                 (i_events.ev0 & `FLAG0_EXT_BITS)
                                 | {7'h00, conv_done_evt},
                                 rd_evt && (ptr_q == `REG_FLAG0)); // [R20] [R15]
            flag1_q <= next_flag(flag1_q,
                                 i_events.ev1 & `FLAG1_BITS,
                                 rd_evt && (ptr_q == `REG_FLAG1)); // [R20]
            flag2_q <= next_flag(flag2_q,
                                 i_events.ev2 & `FLAG2_BITS,
                                 rd_evt && (ptr_q == `REG_FLAG2)); // [R20]
        end
    end

    // Masked interrupt; unmasked fault.
    assign int_d = |(flag0_q & mask0_q)
                   || |(flag1_q & mask1_q)
                   || |(flag2_q & mask2_q); // [R13]
    assign fault_d = |(i_events.ev1 & `FAULT1_BITS)
                     || |(i_events.ev2 & `FAULT2_BITS); // [R14]

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_int_n_oe <= 1'b0;
            o_fault_n_oe <= 1'b0;
        end else begin
            o_int_n_oe <= int_d; // [R22] [R13]
            o_fault_n_oe <= fault_d; // [R14]
        end
    end

endmodule
`default_nettype wire

// ---- i2c_diag_host_port_assertions.sv ----
// Pin and register assertions for the diagnostic port.
`timescale 1ns/1ns
`default_nettype none
module i2c_diag_host_port_assertions (
    input wire logic                  i_core_clk,
    input wire logic                  i_reset_n,
    input wire logic                  i_scl,
    input wire logic                  i_enable,
    input wire logic [1:0]            i_address_select_pin,
    input wire diag_pkg::event_vec_t  i_events,
    input wire logic                  i_conv_done,
    input wire diag_pkg::sample_set_t i_samples,
    input wire logic                  o_scl_o,
    input wire logic                  o_scl_oe,
    input wire logic                  o_sda_o,
    input wire logic                  o_sda_oe,
    input wire logic                  o_int_n_o,
    input wire logic                  o_fault_n_o,
    input wire logic                  o_fault_n_oe,
    input wire logic [6:0]            o_own_addr,
    input wire logic                  o_conv_start,
    input wire logic                  o_conv_busy,
    input wire diag_pkg::sample_set_t o_samples,
    input wire logic signed [15:0]    o_die_temp_dc
);
    wire logic flt = |{i_events.ev1[6:0], i_events.ev2[2:0]};
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    a_scl_released: assert property (!o_scl_oe && !o_scl_o)
        else $error("clock pin driven");
    a_pins_open_drain: assert property (!o_sda_o && !o_int_n_o && !o_fault_n_o)
        else $error("pin driven high");
    a_fault_unmasked: assert property ($rose(flt) |-> ##[1:4] o_fault_n_oe)
        else $error("fault pin missed");
    a_addr_latched: assert property ($rose(i_enable) ##1 i_enable [*6]
        |-> o_own_addr == {5'h0c, i_address_select_pin}) else $error("own address");
    a_start_pulse: assert property (o_conv_start |-> o_conv_busy ##1 !o_conv_start)
        else $error("start pulse");
    a_done_taken: assert property (o_conv_busy && i_conv_done
        |=> !o_conv_busy && o_samples == $past(i_samples)) else $error("done not taken");
    a_samples_hold: assert property (!(o_conv_busy && i_conv_done) |=> $stable(o_samples))
        else $error("samples moved");
    a_temp_scale: assert property ($past(i_reset_n) |-> o_die_temp_dc ==
        $signed(16'd35 * {8'h00, $past(o_samples.temp)} - 16'd2700)) else $error("temp");
    a_sda_low_only: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data moved with clock high");
endmodule
`default_nettype wire

// ---- i2c_master_model.sv ----
// Two-wire bus master model.
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
    output logic      o_scl,
    output logic      o_sda_oe,
    input  wire logic i_sda
);
    localparam int Q = 625;
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic recover();
        repeat (3) begin
            #40 o_scl = 1'b0;
            #40 o_scl = 1'b1;
        end
    endtask
    task automatic bit_x(input logic b, output logic r);
        o_sda_oe = !b;
        #Q o_scl = 1'b1;
        #Q r = i_sda;
        #Q o_scl = 1'b0;
        #Q;
    endtask
    task automatic start();
        o_sda_oe = 1'b0;
        #Q o_scl = 1'b1;
        #Q o_sda_oe = 1'b1;
        #Q o_scl = 1'b0;
        #Q;
    endtask
    task automatic xbyte(input logic [7:0] d, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
        bit_x(1'b1, a);
        a = !a;
    endtask
    task automatic frame(input logic [6:0] a, input logic [7:0] p, d, input logic rd,
                         output logic [7:0] q, output logic [3:0] k);
        start();
        xbyte({a, 1'b0}, q, k[3]);
        xbyte(p, q, k[2]);
        if (rd) begin
            start();
            xbyte({a, 1'b1}, q, k[1]);
            xbyte(8'hff, q, k[0]);
        end else begin
            xbyte(d, q, k[1]);
            k[0] = 1'b0;
        end
        o_sda_oe = 1'b1;
        #Q o_scl = 1'b1;
        #Q o_sda_oe = 1'b0;
        #(4 * Q);
    endtask
endmodule
`default_nettype wire

// ---- i2c_diag_host_port_bench.sv ----
// Self-checking bench for the diagnostic port.
`timescale 1ns/1ns
`default_nettype none
module i2c_diag_host_port_bench;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  en = 1'b0;
    logic [1:0]            sel = 2'h0;
    logic                  done = 1'b0;
    diag_pkg::event_vec_t  ev = '0;
    diag_pkg::sample_set_t smp = '0;
    diag_pkg::sample_set_t o_smp;
    logic [7:0]            q;
    logic [3:0]            k;
    logic [6:0]            own;
    logic signed [15:0]    temp;
    logic [15:0]           mv;
    logic [16:0]           uv;
    logic                  busy;
    wire logic             scl, m_oe, d_oe, int_oe, flt_oe;
    wire logic             sda = !(m_oe | d_oe);
    int                    fail_count = 0;
    int                    tests_run = 0;
    int                    cyc = 0;
    i2c_master_model i2c_master_model_inst (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));
    i2c_diag_host_port i2c_diag_host_port_inst (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_scl(scl), .o_scl_o(), .o_scl_oe(),
        .i_sda(sda), .o_sda_o(), .o_sda_oe(d_oe), .o_int_n_o(), .o_int_n_oe(int_oe),
        .o_fault_n_o(), .o_fault_n_oe(flt_oe), .i_enable(en), .i_address_select_pin(sel),
        .o_own_addr(own), .i_events(ev), .o_conv_start(), .o_conv_busy(busy),
        .i_conv_done(done), .i_samples(smp), .o_samples(o_smp), .o_bus_voltage_mv(mv),
        .o_load_sense_uv(uv), .o_die_temp_dc(temp));
    always #50 clk = ~clk;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic xf(input logic [6:0] a, input logic [7:0] p, d, input logic r,
                      input logic [3:0] ek);
        i2c_master_model_inst.frame(a, p, d, r, q, k);
        tick(1);
        chk("ack", k, ek);
    endtask
    task automatic rd(input logic [7:0] p, e);
        xf(7'h30, p, 8'h00, 1'b1, 4'he);
        chk("rdata", q, e);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        i2c_master_model_inst.recover();
        tick(8);
        rst_n = 1'b1;
        tick(3);
        for (int c = 3; c >= 0; c--) begin
            en = 1'b0;
            sel = c[1:0];
            tick(3);
            en = 1'b1;
            tick(8);
            chk("addr", own, {5'h0c, sel});
            xf({5'h0c, ~sel}, 8'h07, 8'h00, 1'b0, 4'h0);
        end
        xf(7'h00, 8'h07, 8'h00, 1'b0, 4'h0);
        xf(7'h30, 8'h07, 8'h5a, 1'b0, 4'he);
        rd(8'h07, 8'h5a);
        rd(8'h20, 8'h00);
        xf(7'h30, 8'h05, 8'h01, 1'b0, 4'he);
        chk("busy", busy, 1'b1);
        rd(8'h05, 8'h01);
        smp = '{8'hff, 8'h80, 8'h2c};
        done = 1'b1;
        tick(1);
        done = 1'b0;
        smp = '0;
        tick(3);
        chk("busy", busy, 1'b0);
        chk("temp", $unsigned(temp), $unsigned(16'(35 * 44 - 2700)));
        chk("smp", o_smp, 24'hff802c);
        chk("mv", mv, 16'd19800);
        chk("uv", uv, 17'd64501);
        rd(8'h11, 8'hff);
        rd(8'h10, 8'h80);
        rd(8'h12, 8'h2c);
        rd(8'h0a, 8'h01);
        rd(8'h0a, 8'h00);
        xf(7'h30, 8'h08, 8'h01, 1'b0, 4'he);
        ev.ev1 = 8'h01;
        tick(6);
        chk("int", int_oe, 1'b1);
        ev.ev1 = 8'h00;
        tick(6);
        chk("int", int_oe, 1'b1);
        rd(8'h0b, 8'h01);
        tick(4);
        chk("int", int_oe, 1'b0);
        xf(7'h30, 8'h08, 8'h00, 1'b0, 4'he);
        ev.ev1 = 8'h01;
        tick(6);
        chk("int", int_oe, 1'b0);
        chk("fault", flt_oe, 1'b1);
        results();
    end
endmodule
bind i2c_diag_host_port i2c_diag_host_port_assertions chk_inst (.*);
`default_nettype wire
